// ===== rtl/tc_segment_authenticator.sv
// segment authenticator with its output octet fifo
`timescale 1ns/1ps
`default_nettype none

module octet_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = auth_pkg::FIFO_DEPTH
) (
	// clocking
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	// fill side
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	// drain side
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("octet_fifo: depth must be a power of two, at least 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_reg, wp_next, rp_reg, rp_next;
	logic rv_reg, rv_next, wrdy_reg, wrdy_next;
	logic [WIDTH-1:0] rd_reg, rd_next;
	logic push, pop;
	always_comb begin
		push = wr_valid && wrdy_reg;
		wp_next = wp_reg + (AW+1)'(push);
		rp_next = rp_reg;
		rv_next = rv_reg;
		rd_next = rd_reg;
		pop = (!rv_reg || rd_ready) && (rp_reg != wp_reg);
		if (rv_reg && rd_ready)
			rv_next = 1'b0;
		if (pop) begin
			rd_next = mem[rp_reg[AW-1:0]];
			rv_next = 1'b1;
			rp_next = rp_reg + (AW+1)'(1);
		end
		// registered ready stays honest by reserving one slot
		wrdy_next = (wp_next - rp_next) < (AW+1)'(DEPTH - 1);
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wp_reg <= '0;
			rp_reg <= '0;
			rv_reg <= 1'b0;
			rd_reg <= '0;
			wrdy_reg <= 1'b0;
		end else if (ce) begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			rv_reg <= rv_next;
			rd_reg <= rd_next;
			wrdy_reg <= wrdy_next;
		end
	end
	always_ff @(posedge clock) begin
		if (ce && push)
			mem[wp_reg[AW-1:0]] <= wr_data;
	end
	assign wr_ready = wrdy_reg;
	assign rd_valid = rv_reg;
	assign rd_data = rd_reg;
endmodule

// What this block does
// - signature part of the tail is five octets
// - tail is nine octets, signature then four-octet sequence channel value
// - authenticated segment spans 10 to 249 octets
// - trailer kept per unit choice and external tail flag; none when unauthenticated
// - map low five bits against pointer choose authenticated pairs
// - pair pointer comes from mission read-only data, not a register
// - source select one uses external unit, zero the internal one
// - bypass one disables both units and passes segments straight through
// - while disabled keep all octets, ignore pointer, map 63 ordinary
// - produce an 80-bit status word for telemetry
// - recompute a 40-bit signature over each authenticated segment with the key
// - 60-bit lfsr with key coefficients compresses message to presignature
// - lfsr starts with only bit zero set for each segment
// - hash message, sequence channel value, then 24 generated zeros
// - authenticated segments under ten octets are rejected as too short
// - knapsack sums selected 48-bit weights modulo two to the 48
// - knapsack sum bit zero is its most significant bit
// - drop eight low sum bits, leaving the 40-bit signature
// - compare received and computed signatures bit for bit
// - on match check count against indicated channel, increment, forward unless map 63
// - strip the tail from every segment the internal unit authorises
// - key holds 60 weights of 48 bits plus 60 coefficients
module tc_segment_authenticator #(
	parameter int FIFO_DEPTH = auth_pkg::FIFO_DEPTH
) (
	// clocking
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	// configuration pins
	input wire logic auth_source_select,
	input wire logic auth_bypass,
	input wire logic ext_tail_keep_flag,
	// mission read-only data: pair pointer and key
	input wire logic [4:0] map_pointer,
	input wire logic [auth_pkg::LFSR_BITS-1:0] hash_feedback_coeff,
	output logic [5:0] weight_index,
	input wire logic [auth_pkg::KNAP_BITS-1:0] weight_data,
	// segments from the back-end buffer
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	input wire logic in_last,
	// segments to the segmentation layer
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data,
	output logic out_last,
	// telemetry
	output logic [auth_pkg::STATUS_BITS-1:0] auth_status_report
);
	typedef enum {S_RECV, S_HASH, S_KNAP, S_CHECK, S_EMIT} state_e;
	state_e st_reg, st_next;
	logic [7:0] seg [auth_pkg::MAX_SEG_OCTETS];
	logic [7:0] len_reg, len_next, idx_reg, idx_next, emit_len_reg, emit_len_next;
	logic [2:0] bit_reg, bit_next;
	logic long_reg, long_next, strip_reg, strip_next, drop_reg, drop_next;
	logic [auth_pkg::LFSR_BITS-1:0] lfsr_reg, lfsr_next;
	logic [auth_pkg::KNAP_BITS-1:0] sum_reg, sum_next;
	logic [5:0] wi_reg, wi_next;
	logic [auth_pkg::LAC_COUNT_BITS-1:0] lac_p_reg, lac_p_next, lac_a_reg, lac_a_next;
	logic [auth_pkg::REC_COUNT_BITS-1:0] lac_r_reg, lac_r_next;
	logic [7:0] flags_reg, flags_next;
	logic [3:0] rej_reg, rej_next;
	logic rdy_reg, rdy_next;
	logic store, fifo_wr, fifo_wrdy, fb, mbit, authed, lac_ok;
	logic [5:0] map_id;
	logic [7:0] oct, k, tail0;
	logic [auth_pkg::SIG_BITS-1:0] rx_sig;
	logic [31:0] rx_lac;
	logic [auth_pkg::LAC_COUNT_BITS-1:0] cur_lac;
	logic [8:0] fifo_in, fifo_out;

	always_comb begin
		st_next = st_reg;
		len_next = len_reg;
		idx_next = idx_reg;
		bit_next = bit_reg;
		long_next = long_reg;
		strip_next = strip_reg;
		drop_next = drop_reg;
		emit_len_next = emit_len_reg;
		lfsr_next = lfsr_reg;
		sum_next = sum_reg;
		wi_next = wi_reg;
		lac_p_next = lac_p_reg;
		lac_a_next = lac_a_reg;
		lac_r_next = lac_r_reg;
		flags_next = flags_reg;
		rej_next = rej_reg;
		rdy_next = rdy_reg;
		store = 1'b0;
		fifo_wr = 1'b0;
		map_id = seg[0][5:0];
		tail0 = len_reg - 8'(auth_pkg::TAIL_OCTETS);
		rx_sig = {seg[tail0], seg[8'(tail0 + 8'h01)], seg[8'(tail0 + 8'h02)],
			seg[8'(tail0 + 8'h03)], seg[8'(tail0 + 8'h04)]};
		rx_lac = {seg[8'(len_reg - 8'h04)], seg[8'(len_reg - 8'h03)],
			seg[8'(len_reg - 8'h02)], seg[8'(len_reg - 8'h01)]};
		// pointer read live from mission data; pair n and n+32 share low bits
		authed = (map_id[4:0] <= map_pointer) || (map_id == auth_pkg::CTRL_MAP);
		unique case (rx_lac[31:30])
			auth_pkg::LAC_PRINCIPAL: cur_lac = lac_p_reg;
			auth_pkg::LAC_AUXILIARY: cur_lac = lac_a_reg;
			auth_pkg::LAC_RECOVERY: cur_lac = {auth_pkg::REC_HIGH_ONES, lac_r_reg};
			default: cur_lac = ~rx_lac[29:0];
		endcase
		lac_ok = (rx_lac[31:30] != 2'h3) && (cur_lac == rx_lac[29:0]);
		// hashed octet k: message, then sequence channel value, then zero fill
		k = idx_reg;
		if (k < tail0)
			oct = seg[k];
		else if (k < 8'(len_reg - 8'(auth_pkg::LAC_OCTETS + 1)))
			oct = seg[8'(k + 8'(auth_pkg::SIG_OCTETS))];
		else
			oct = 8'h00;
		mbit = oct[3'h7 - bit_reg];
		fb = lfsr_reg[auth_pkg::LFSR_BITS-1] ^ mbit;
		unique case (st_reg)
			S_RECV: begin
				rdy_next = 1'b1;
				if (in_valid && rdy_reg) begin
					store = !long_reg && (len_reg < 8'(auth_pkg::MAX_SEG_OCTETS));
					if (!store)
						long_next = 1'b1;
					else
						len_next = len_reg + 8'h01;
					if (in_last) begin
						rdy_next = 1'b0;
						idx_next = 8'h00;
						bit_next = 3'h0;
						lfsr_next = auth_pkg::LFSR_INIT;
						st_next = S_EMIT;
						strip_next = 1'b0;
						drop_next = 1'b0;
						emit_len_next = store ? len_reg + 8'h01 : len_reg;
					end
				end
				if (in_valid && rdy_reg && in_last) begin
					// decisions use the header octet already stored
					if (auth_bypass) begin
						flags_next[7] = 1'b1;
					end else if (!authed && len_reg != 8'h00) begin
						flags_next[7] = 1'b0;
					end else if (auth_source_select) begin
						// external unit checks; tail handed on unless the flag drops it
						if (ext_tail_keep_flag && emit_len_next > 8'(auth_pkg::TAIL_OCTETS))
							emit_len_next = emit_len_next - 8'(auth_pkg::TAIL_OCTETS);
					end else if (emit_len_next < 8'(auth_pkg::MIN_AUTH_OCTETS) || long_next) begin
						// rejected segment still passes through emit so input stays shut a cycle
						drop_next = 1'b1;
						flags_next[3] = 1'b1;
						rej_next = rej_reg + 4'h1;
					end else begin
						st_next = S_HASH;
					end
				end
			end
			S_HASH: begin
				lfsr_next = {lfsr_reg[auth_pkg::LFSR_BITS-2:0], 1'b0}
					^ ({auth_pkg::LFSR_BITS{fb}} & {hash_feedback_coeff[auth_pkg::LFSR_BITS-1:1], 1'b1});
				bit_next = bit_reg + 3'h1;
				if (bit_reg == 3'h7) begin
					idx_next = idx_reg + 8'h01;
					if (idx_reg == 8'(len_reg - 8'(auth_pkg::TAIL_OCTETS - auth_pkg::LAC_OCTETS
						- auth_pkg::FILL_OCTETS + 1))) begin
						st_next = S_KNAP;
						sum_next = auth_pkg::KNAP_INIT;
						wi_next = 6'h00;
					end
				end
			end
			S_KNAP: begin
				if (lfsr_reg[wi_reg])
					sum_next = sum_reg + weight_data;
				// index parks on the last weight rather than running past the rom
				if (wi_reg == 6'(auth_pkg::LFSR_BITS - 1))
					st_next = S_CHECK;
				else
					wi_next = wi_reg + 6'h01;
			end
			S_CHECK: begin
				// sum msb is signature bit 0; low eight bits are discarded
				flags_next[1] = sum_reg[auth_pkg::KNAP_BITS-1:auth_pkg::DROP_BITS] != rx_sig;
				flags_next[2] = !lac_ok;
				flags_next[0] = !flags_next[1] && lac_ok;
				flags_next[4] = map_id == auth_pkg::CTRL_MAP;
				if (flags_next[0]) begin
					unique case (rx_lac[31:30])
						auth_pkg::LAC_PRINCIPAL: lac_p_next = lac_p_reg + 30'h0000_0001;
						auth_pkg::LAC_AUXILIARY: lac_a_next = lac_a_reg + 30'h0000_0001;
						default: lac_r_next = lac_r_reg + 8'h01;
					endcase
					emit_len_next = tail0;
					drop_next = map_id == auth_pkg::CTRL_MAP;
				end else begin
					drop_next = 1'b1;
					rej_next = rej_reg + 4'h1;
				end
				idx_next = 8'h00;
				st_next = S_EMIT;
			end
			S_EMIT: begin
				fifo_wr = !drop_reg && fifo_wrdy;
				if (drop_reg || (fifo_wrdy && idx_reg == 8'(emit_len_reg - 8'h01))) begin
					st_next = S_RECV;
					rdy_next = 1'b1;
					len_next = 8'h00;
					long_next = 1'b0;
				end else if (fifo_wrdy) begin
					idx_next = idx_reg + 8'h01;
				end
			end
		endcase
		// non-hashed paths enter emit directly from receive
		if (st_reg == S_RECV && st_next == S_EMIT)
			idx_next = 8'h00;
		flags_next[6] = auth_source_select;
		flags_next[5] = ext_tail_keep_flag;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_reg <= S_RECV;
			len_reg <= 8'h00;
			idx_reg <= 8'h00;
			bit_reg <= 3'h0;
			long_reg <= 1'b0;
			strip_reg <= 1'b0;
			drop_reg <= 1'b0;
			emit_len_reg <= 8'h00;
			lfsr_reg <= auth_pkg::LFSR_INIT;
			sum_reg <= auth_pkg::KNAP_INIT;
			wi_reg <= 6'h00;
			lac_p_reg <= auth_pkg::LAC_RESET;
			lac_a_reg <= auth_pkg::LAC_RESET;
			lac_r_reg <= 8'h00;
			flags_reg <= 8'h00;
			rej_reg <= 4'h0;
			rdy_reg <= 1'b0;
		end else if (ce) begin
			st_reg <= st_next;
			len_reg <= len_next;
			idx_reg <= idx_next;
			bit_reg <= bit_next;
			long_reg <= long_next;
			strip_reg <= strip_next;
			drop_reg <= drop_next;
			emit_len_reg <= emit_len_next;
			lfsr_reg <= lfsr_next;
			sum_reg <= sum_next;
			wi_reg <= wi_next;
			lac_p_reg <= lac_p_next;
			lac_a_reg <= lac_a_next;
			lac_r_reg <= lac_r_next;
			flags_reg <= flags_next;
			rej_reg <= rej_next;
			rdy_reg <= rdy_next;
		end
	end

	always_ff @(posedge clock) begin
		if (ce && store)
			seg[len_reg] <= in_data;
	end

	assign fifo_in = {idx_reg == 8'(emit_len_reg - 8'h01), seg[idx_reg]};
	octet_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) out_buf (
		.clock(clock),
		.rstn(rstn),
		.ce(ce),
		.wr_valid(fifo_wr),
		.wr_ready(fifo_wrdy),
		.wr_data(fifo_in),
		.rd_valid(out_valid),
		.rd_ready(out_ready),
		.rd_data(fifo_out)
	);
	assign out_data = fifo_out[7:0];
	assign out_last = fifo_out[8];
	assign in_ready = rdy_reg;
	assign weight_index = wi_reg;
	// status word: flags, principal, auxiliary, recovery count, reject tally
	assign auth_status_report = {flags_reg, lac_p_reg, lac_a_reg, lac_r_reg, rej_reg};
endmodule

`default_nettype wire

// ===== rtl/auth_pkg.sv
// constants shared by the segment authenticator and its output buffer
package auth_pkg;
	localparam int SIG_OCTETS = 5;
	localparam int LAC_OCTETS = 4;
	localparam int TAIL_OCTETS = SIG_OCTETS + LAC_OCTETS;
	localparam int MAX_SEG_OCTETS = 249;
	localparam int MIN_AUTH_OCTETS = 10;
	localparam int FILL_OCTETS = 3;
	localparam int LFSR_BITS = 60;
	localparam int KNAP_BITS = 48;
	localparam int SIG_BITS = 40;
	localparam int DROP_BITS = 8;
	localparam int LAC_COUNT_BITS = 30;
	localparam int REC_COUNT_BITS = 8;
	localparam int STATUS_BITS = 80;
	localparam int FIFO_DEPTH = 32;
	localparam logic [5:0] CTRL_MAP = 6'h3F;
	localparam logic [1:0] LAC_PRINCIPAL = 2'h0;
	localparam logic [1:0] LAC_AUXILIARY = 2'h1;
	localparam logic [1:0] LAC_RECOVERY = 2'h2;
	localparam logic [LFSR_BITS-1:0] LFSR_INIT = 60'h000_0000_0000_0001;
	localparam logic [KNAP_BITS-1:0] KNAP_INIT = 48'h0000_0000_0000;
	localparam logic [LAC_COUNT_BITS-1:0] LAC_RESET = 30'h0000_0000;
	localparam logic [LAC_COUNT_BITS-REC_COUNT_BITS-1:0] REC_HIGH_ONES = 22'h3F_FFFF;
endpackage

// ===== test/seg_auth_checker.sv
// port-level assertions for the segment authenticator
`timescale 1ns/1ps
`default_nettype none
module seg_auth_checker (
	// clocking
	input wire logic clock,
	input wire logic rstn,
	input wire logic ce,
	// streams
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic in_last,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [7:0] out_data,
	input wire logic out_last,
	// key fetch and telemetry
	input wire logic [5:0] weight_index,
	input wire logic [auth_pkg::STATUS_BITS-1:0] auth_status_report
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	a_reset_quiet: assert property ($rose(rstn) |-> !in_ready && !out_valid &&
		weight_index == 6'h0 && auth_status_report == 80'h0)
		else $error("outputs not cleared by reset");
	a_ready_after_reset: assert property ($rose(rstn) && ce |=> in_ready)
		else $error("input not opened after reset");
	a_last_busy: assert property (in_valid && in_ready && in_last && ce |=> !in_ready)
		else $error("input reopened too soon after last octet");
	a_out_held: assert property (out_valid && !out_ready |=>
		out_valid && $stable(out_data) && $stable(out_last))
		else $error("output octet changed while stalled");
	a_ce_freeze: assert property (!ce |=> $stable(out_valid) && $stable(in_ready) &&
		$stable(weight_index) && $stable(auth_status_report))
		else $error("state moved with clock enable low");
	a_weight_range: assert property (weight_index < 6'h3C)
		else $error("weight index beyond last weight");
	a_counts_idle: assert property (in_ready && $past(in_ready) |->
		$stable(auth_status_report[71:0]))
		else $error("counts changed with no segment in work");
	a_counts_cleared: assert property ($rose(rstn) |=> auth_status_report[71:4] == 68'h0)
		else $error("counts not zero after reset");
endmodule
`default_nettype wire

// ===== test/seg_far_side.sv
// key rom, pair pointer and segmentation layer pacing
`timescale 1ns/1ps
`default_nettype none
module seg_far_side #(
	parameter logic [59:0] COEFF = 60'h0
) (
	// clocking
	input wire logic clock,
	// pacing set by the bench
	input wire logic hold,
	input wire logic slow,
	// mission read-only data
	output logic [4:0] map_pointer,
	output logic [59:0] coeff,
	input wire logic [5:0] weight_index,
	output logic [47:0] weight_data,
	// segmentation layer acceptance
	output logic out_ready
);
	logic phase = 1'h0;
	assign map_pointer = 5'h04;
	assign coeff = COEFF;
	// same weight for an index on every fetch, as a rom gives
	assign weight_data = 48'h9E37_79B9_7F4A * 48'(weight_index + 6'h1);
	always @(negedge clock) phase <= ~phase;
	// slow mode takes an octet only on every other cycle
	assign out_ready = !hold && !(slow && phase);
endmodule
`default_nettype wire

// ===== test/tc_segment_authenticator_tb.sv
// self-checking bench for the segment authenticator
`timescale 1ns/1ps
`default_nettype none
module tc_segment_authenticator_tb;
	typedef logic [7:0] oct_q_t[$];
	localparam logic [59:0] COEFF = 60'hA5C_3F09_6E1D_7B24;
	logic clock = 1'h0;
	logic rstn = 1'h0;
	logic ce = 1'h1;
	logic src = 1'h0;
	logic bypass = 1'h0;
	logic keep = 1'h0;
	logic in_valid = 1'h0;
	logic in_last = 1'h0;
	logic [7:0] in_data = 8'h00;
	logic hold = 1'h0;
	logic slow = 1'h0;
	wire logic in_ready, out_valid, out_ready, out_last;
	wire logic [7:0] out_data;
	wire logic [4:0] map_pointer;
	wire logic [59:0] coeff;
	wire logic [5:0] weight_index;
	wire logic [47:0] weight_data;
	wire logic [79:0] status;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;
	logic [8:0] got[$];
	always #50 clock = ~clock;
	tc_segment_authenticator uut (.clock(clock), .rstn(rstn), .ce(ce),
		.auth_source_select(src), .auth_bypass(bypass), .ext_tail_keep_flag(keep),
		.map_pointer(map_pointer), .hash_feedback_coeff(coeff),
		.weight_index(weight_index), .weight_data(weight_data),
		.in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_last(in_last),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
		.out_last(out_last), .auth_status_report(status));
	seg_far_side #(.COEFF(COEFF)) far (.clock(clock), .hold(hold), .slow(slow),
		.map_pointer(map_pointer), .coeff(coeff), .weight_index(weight_index),
		.weight_data(weight_data), .out_ready(out_ready));
	always @(posedge clock) if (out_valid && out_ready && ce) got.push_back({out_last, out_data});
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic check(input string what, input logic [8:0] exp, input logic [8:0] seen);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [47:0] weight(input int j);
		return 48'h9E37_79B9_7F4A * 48'(j + 1);
	endfunction
	function automatic logic [39:0] sig_of(input oct_q_t m);
		logic [59:0] p;
		logic [47:0] s;
		logic fb;
		p = auth_pkg::LFSR_INIT;
		for (int k = 0; k < m.size() * 8 + 24; k++) begin
			fb = p[59] ^ (k < m.size() * 8 && m[k / 8][7 - k % 8]);
			p = {p[58:0], fb} ^ ({60{fb}} & COEFF & ~60'h1);
		end
		s = 48'h0;
		for (int j = 0; j < 60; j++) if (p[j]) s += weight(j);
		return s[47:8];
	endfunction
	function automatic oct_q_t plain(input logic [7:0] hdr, input int len);
		plain = {hdr};
		for (int i = 1; i < len; i++) plain.push_back(8'(i * 37));
	endfunction
	task automatic send_seg(input oct_q_t seg);
		foreach (seg[k]) begin
			@(negedge clock);
			in_valid = 1'h1;
			in_data = seg[k];
			in_last = k == seg.size() - 1;
			while (!in_ready) @(negedge clock);
			@(posedge clock);
		end
		@(negedge clock);
		in_valid = 1'h0;
		in_last = 1'h0;
	endtask
	// first n octets expected, last flag on the final one
	task automatic compare(input oct_q_t seg, input int n);
		check("count", 9'(n), 9'(got.size()));
		for (int i = 0; i < n && i < got.size(); i++) check("octet", {i == n - 1, seg[i]}, got[i]);
	endtask
	task automatic run_seg(input oct_q_t seg, input int n);
		got.delete();
		send_seg(seg);
		for (int i = 0; i < 4000 && !in_ready; i++) @(negedge clock);
		repeat (60) @(negedge clock);
		compare(seg, n);
	endtask
	task automatic auth_case(input logic [5:0] map, input int nd, input logic [29:0] cnt,
		input logic [39:0] flip, input int n);
		oct_q_t m;
		oct_q_t seg;
		logic [31:0] auth_sequence_channel;
		logic [39:0] s;
		auth_sequence_channel = {auth_pkg::LAC_PRINCIPAL, cnt};
		m = {{2'h3, map}};
		for (int i = 0; i < nd; i++) m.push_back(8'(i * 29 + 7));
		seg = m;
		for (int i = 3; i >= 0; i--) m.push_back(auth_sequence_channel[i * 8 +: 8]);
		s = sig_of(m) ^ flip;
		for (int i = 4; i >= 0; i--) seg.push_back(s[i * 8 +: 8]);
		for (int i = 3; i >= 0; i--) seg.push_back(auth_sequence_channel[i * 8 +: 8]);
		run_seg(seg, n);
	endtask
	// stalled sink fills the fifo until input is refused, then drains it
	task automatic fill_drain();
		oct_q_t seg;
		seg = plain(8'hFF, 40);
		bypass = 1'h1;
		hold = 1'h1;
		got.delete();
		fork
			send_seg(seg);
			begin
				repeat (80) @(negedge clock);
				check("refused", 9'h0, {8'h00, in_ready});
				check("pending", 9'h1, {8'h00, out_valid});
				ce = 1'h0;
				repeat (4) @(negedge clock);
				ce = 1'h1;
				hold = 1'h0;
			end
		join
		repeat (60) @(negedge clock);
		compare(seg, 40);
		check("empty", 9'h0, {8'h00, out_valid});
		bypass = 1'h0;
	endtask
	task automatic unauth_pass();
		slow = 1'h1;
		run_seg(plain(8'hE5, 5), 5);
		slow = 1'h0;
	endtask
	task automatic internal_auth();
		auth_case(6'h24, 0, 30'h0, 40'h0, 1);
		auth_case(6'h04, 3, 30'h1, 40'h0, 4);
		auth_case(6'h24, 2, 30'h2, 40'h1, 0);
		auth_case(6'h24, 2, 30'h1, 40'h0, 0);
		run_seg(plain(8'hE4, 9), 0);
		auth_case(6'h24, 5, 30'h2, 40'h0, 6);
		check("principal", 9'h3, status[50:42]);
		check("rejects", 9'h3, {5'h00, status[3:0]});
	endtask
	task automatic external_auth();
		src = 1'h1;
		auth_case(6'h24, 2, 30'h0, 40'h5, 12);
		keep = 1'h1;
		auth_case(6'h24, 2, 30'h0, 40'h5, 3);
		src = 1'h0;
		keep = 1'h0;
	endtask
	initial begin
		repeat (5) @(negedge clock);
		rstn = 1'h1;
		repeat (2) @(negedge clock);
		fill_drain();
		unauth_pass();
		internal_auth();
		external_auth();
		finish_test();
	end
endmodule
bind tc_segment_authenticator seg_auth_checker chk (.clock(clock), .rstn(rstn), .ce(ce),
	.in_valid(in_valid), .in_ready(in_ready), .in_last(in_last),
	.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_last(out_last),
	.weight_index(weight_index), .auth_status_report(auth_status_report));
`default_nettype wire
